// ---- rtl/pwm_timebase_defs.svh ----
`ifndef PWM_TIMEBASE_DEFS_SVH
`define PWM_TIMEBASE_DEFS_SVH
// register indices; the byte address on the bus is four times the index
`define IDX_EXT_RESET_SRC    16'h048c
`define IDX_CLOCK_SEL        16'h048d
`define IDX_LOAD_TRIG        16'h048e
`define IDX_PERIOD_LOW       16'h048f
`define IDX_PERIOD_HIGH      16'h0490
`define IDX_PRESCALE         16'h0491
`define IDX_POSTSCALE        16'h0492
`define IDX_SLICE_FLAGS      16'h0493
`define IDX_CONTROL          16'h0495
`define IDX_STATUS           16'h04a0
// field layouts
`define ERS_SEL_W            4
`define CLK_SEL_W            4
`define LDS_SEL_W            3
// control register bits
`define CTL_EN_BIT           7
`define CTL_LD_BIT           2
`define CTL_POL_BIT          1
`define CTL_NOW_BIT          0
// clock source codes
`define CLK_SYSTEM           4'h2
`define CLK_RESERVED         4'hf
// external reset codes
`define ERS_OFF              4'h0
`define ERS_PIN              4'h1
`define ERS_SLICE_LO         4'h2
`define ERS_SLICE_HI         4'h9
`define ERS_CELL_LO          4'ha
`define ERS_CELL_HI          4'hd
// load trigger codes
`define LDS_OFF              3'h0
`define LDS_PIN_LO           3'h1
`define LDS_CELL_LO          3'h3
`define LDS_RESERVED         3'h7
// reset values
`define PERIOD_RST           16'h0000
`define PRESCALE_RST         8'h00
`define SEL_RST              8'h00
`endif

// ---- rtl/pwm_timebase_pkg.sv ----
package pwm_timebase_pkg;
  // external reset hold sequencing, gray coded along idle -> armed -> held
  typedef enum logic [1:0]
  {
    ERS_IDLE  = 2'b00,
    ERS_ARMED = 2'b01,
    ERS_HELD  = 2'b11
  } ers_state_t;
endpackage

// ---- rtl/pwm_clock_select.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_defs.svh"
// picks one of sixteen clock sources and turns its rising edges into pclk enables
module pwm_clock_select
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [15:0]           src_async,   // asynchronous sources, bit = select code
  input  wire logic [`CLK_SEL_W-1:0] clk_sel,     // selected source code
  input  wire logic                  sleep,       // device sleep, same clock domain
  output logic                       tick         // one pclk pulse per source edge
);
  logic [15:0] sync1_q;   // first stage, read only by second stage
  logic [15:0] sync2_q;   // settled copies
  logic        sel_q;     // previous level of selected source
  logic        pick;      // selected settled level

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on every source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end
    else
    begin
      sync1_q <= src_async;
      sync2_q <= sync1_q;
    end
  end

  assign pick = sync2_q[clk_sel];

  //////////////////////////////////////////////////////////////////////////////
  // edge detect; a select change may fake one edge, so software should disable first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= 1'b0;
      tick  <= 1'b0;
    end
    else
    begin
      sel_q <= pick;
      // R14: reserved code never ticks
      if (clk_sel == `CLK_RESERVED)
        tick <= 1'b0;
      // R3: system clock halts in sleep
      else if (clk_sel == `CLK_SYSTEM)
        tick <= !sleep;
      else
        tick <= pick & ~sel_q;
    end
  end

  // R3: no system clock tick in sleep
  a_sleep_stops_tick: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (clk_sel == `CLK_SYSTEM && sleep) |=> !tick)
    else $error("system clock ticked during sleep");
  // R14: reserved code gives no edge
  a_reserved_no_tick: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (clk_sel == `CLK_RESERVED) |=> !tick)
    else $error("reserved clock code produced a tick");
endmodule
`default_nettype wire

// ---- rtl/pwm_timebase.sv ----
// Behaviour
// R1: ext reset select, 0/14/15/own outputs disable
// R2: four bit counter clock source select
// R3: system clock stops in sleep
// R4: three bit load trigger, 0 off, 7 reserved
// R5: codes 1-2 pins, 3-6 logic cells
// R6: sixteen bit period, reset zero
// R7: period reachable as two bytes
// R8: prescaler divides by value plus one
// R9: one interrupt per postscale plus one periods
// R10: counter runs zero to period inclusive
// R11: ext reset clears counters, holds zero
// R12: trigger event requests same load as software
// R13: prescale counter clears while disabled
// R14: reserved clock code never advances counter
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_defs.svh"
module pwm_timebase
  import pwm_timebase_pkg::*;
#(
  parameter int INSTANCE = 1                       // instance number 1..4
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep,                  // device sleep, same domain
  input  wire logic        pwm_pin_input0,
  input  wire logic        pwm_pin_input1,
  input  wire logic        fast_internal_osc,
  input  wire logic        slow_internal_osc,
  input  wire logic        medium_internal_osc_fast,
  input  wire logic        medium_internal_osc_slow,
  input  wire logic        secondary_osc,
  input  wire logic        external_osc,
  input  wire logic        reference_clock_out,
  input  wire logic        numeric_osc_out,
  input  wire logic [3:0]  logic_cell_out,          // logic cells one to four
  input  wire logic        ext_reset_pin_input,
  input  wire logic [7:0]  other_slice_out,         // slice outputs, reset codes 2..9
  output logic      [15:0] pwm_counter,
  output logic             period_event,
  output logic             period_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ext_reset_source_reg_q;  // reset source code
  logic [7:0]  counter_clock_reg_q;     // clock source code
  logic [7:0]  load_trigger_reg_q;      // trigger source code
  logic [15:0] period_reg_q;            // software period
  logic [15:0] period_buf_q;            // period in use
  logic [7:0]  prescale_reg_q;          // clock prescale
  logic [7:0]  postscale_reg_q;         // period irq postscale
  logic [7:0]  slice_flag_reg_q;        // slice flags, plain storage here
  logic        enable_q;                // module enable
  logic        load_request_q;          // pending buffer transfer
  logic        ers_polarity_q;          // 1: reset source active low
  logic        ers_now_q;               // 1: reset acts on next pwm clock
  logic [7:0]  pre_cnt_q;               // prescale counter
  logic [7:0]  post_cnt_q;              // postscale counter
  logic        pwm_clk_en;              // prescaled pwm clock enable
  logic        tick;                    // selected source edge
  ers_state_t  ers_state_q;             // external reset sequencing
  logic [12:0] trig_sync1_q;            // full stage1 for sources
  logic [12:0] trig_sync2_q;            // settled sources
  logic        trig_prev_q;             // previous selected trigger level
  logic        ers_level;               // selected reset level, polarity applied
  logic        trig_level;              // selected trigger level
  logic        trig_event;              // trigger rising edge
  logic        wr_en;                   // write strobe
  logic        at_top;                  // counter at period value
  logic [15:0] idx;                     // register index from byte address
  logic        enable_prev_q;           // enable one cycle ago

  assign idx = {2'b00, paddr[15:2]};

  // true when the index names a mapped register
  function automatic logic mapped(input logic [15:0] i);
    mapped = (i >= `IDX_EXT_RESET_SRC && i <= `IDX_SLICE_FLAGS) ||
             i == `IDX_CONTROL || i == `IDX_STATUS;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // clock source selection
  pwm_clock_select u_clock_select
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_async ({1'b0, logic_cell_out, numeric_osc_out, reference_clock_out, external_osc,
                 secondary_osc, medium_internal_osc_slow, medium_internal_osc_fast,
                 slow_internal_osc, fast_internal_osc, 1'b0, pwm_pin_input1, pwm_pin_input0}),
    // R2: four bit source code
    .clk_sel   (counter_clock_reg_q[`CLK_SEL_W-1:0]),
    .sleep     (sleep),
    .tick      (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, answer always ready there
  assign wr_en = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      // ready rises in the setup cycle so the access phase ends at once
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(idx);
      if (psel && !penable && !pwrite)
      begin
        case (idx)
          `IDX_EXT_RESET_SRC: prdata <= {24'h000000, ext_reset_source_reg_q};
          `IDX_CLOCK_SEL:     prdata <= {24'h000000, counter_clock_reg_q};
          `IDX_LOAD_TRIG:     prdata <= {24'h000000, load_trigger_reg_q};
          // R7: separate byte views of the period
          `IDX_PERIOD_LOW:    prdata <= {24'h000000, period_reg_q[7:0]};
          `IDX_PERIOD_HIGH:   prdata <= {24'h000000, period_reg_q[15:8]};
          `IDX_PRESCALE:      prdata <= {24'h000000, prescale_reg_q};
          `IDX_POSTSCALE:     prdata <= {24'h000000, postscale_reg_q};
          `IDX_SLICE_FLAGS:   prdata <= {24'h000000, slice_flag_reg_q};
          `IDX_CONTROL:       prdata <= {24'h000000, enable_q, 4'h0, load_request_q,
                                         ers_polarity_q, ers_now_q};
          `IDX_STATUS:        prdata <= {post_cnt_q, 7'h00, ers_state_q == ERS_HELD, pwm_counter};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_reset_source_reg_q <= `SEL_RST;
      counter_clock_reg_q    <= `SEL_RST;
      load_trigger_reg_q     <= `SEL_RST;
      period_reg_q           <= `PERIOD_RST;
      prescale_reg_q         <= `PRESCALE_RST;
      postscale_reg_q        <= `SEL_RST;
      slice_flag_reg_q       <= `SEL_RST;
      enable_q               <= 1'b0;
      ers_polarity_q         <= 1'b0;
      ers_now_q              <= 1'b0;
    end
    else if (wr_en)
    begin
      case (idx)
        // R1: four bit reset source field
        `IDX_EXT_RESET_SRC: ext_reset_source_reg_q <= {4'h0, pwdata[`ERS_SEL_W-1:0]};
        `IDX_CLOCK_SEL:     counter_clock_reg_q    <= {4'h0, pwdata[`CLK_SEL_W-1:0]};
        // R4: three bit trigger field
        `IDX_LOAD_TRIG:     load_trigger_reg_q     <= {5'h00, pwdata[`LDS_SEL_W-1:0]};
        // R6: period value written a byte at a time
        `IDX_PERIOD_LOW:    period_reg_q[7:0]      <= pwdata[7:0];
        `IDX_PERIOD_HIGH:   period_reg_q[15:8]     <= pwdata[7:0];
        `IDX_PRESCALE:      prescale_reg_q         <= pwdata[7:0];
        `IDX_POSTSCALE:     postscale_reg_q        <= pwdata[7:0];
        `IDX_SLICE_FLAGS:   slice_flag_reg_q       <= pwdata[7:0];
        `IDX_CONTROL:
        begin
          enable_q       <= pwdata[`CTL_EN_BIT];
          ers_polarity_q <= pwdata[`CTL_POL_BIT];
          ers_now_q      <= pwdata[`CTL_NOW_BIT];
        end
        default:            enable_q <= enable_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronise reset and trigger sources: pin, slices, load pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_sync1_q <= 13'h0000;
      trig_sync2_q <= 13'h0000;
    end
    else
    begin
      trig_sync1_q <= {pwm_pin_input1, pwm_pin_input0, ext_reset_pin_input, other_slice_out, 2'b00};
      trig_sync2_q <= trig_sync1_q;
    end
  end

  // logic cells get their own two-flop synchroniser, apart from the clock selector's
  logic [3:0] cell_sync1_q;  // stage 1, read only by stage 2
  logic [3:0] cell_sync2_q;  // settled cell outputs

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_sync1_q <= 4'h0;
      cell_sync2_q <= 4'h0;
    end
    else
    begin
      cell_sync1_q <= logic_cell_out;
      cell_sync2_q <= cell_sync1_q;
    end
  end

  function automatic logic logic_cell_sync(input logic [1:0] n);
    logic_cell_sync = cell_sync2_q[n];
  endfunction

  // R1: reset source decode, own outputs and reserved codes disabled
  always_comb
  begin
    logic [3:0] c;
    c = ext_reset_source_reg_q[3:0];
    ers_level = 1'b0;
    if (c == `ERS_PIN)
      ers_level = trig_sync2_q[10];
    else if (c >= `ERS_SLICE_LO && c <= `ERS_SLICE_HI && c[3:1] != 3'(INSTANCE))
      ers_level = trig_sync2_q[3'(c - `ERS_SLICE_LO) + 2];
    else if (c >= `ERS_CELL_LO && c <= `ERS_CELL_HI)
      ers_level = logic_cell_sync(2'(c - `ERS_CELL_LO));
    if (c != `ERS_OFF && c <= `ERS_CELL_HI && !(c[3:1] == 3'(INSTANCE) && c <= `ERS_SLICE_HI))
      ers_level = ers_level ^ ers_polarity_q;
  end

  // R5: load trigger decode; R4: zero and reserved select nothing
  always_comb
  begin
    logic [2:0] t;
    t = load_trigger_reg_q[2:0];
    trig_level = 1'b0;
    if (t >= `LDS_PIN_LO && t < `LDS_CELL_LO)
      trig_level = trig_sync2_q[3'(t - `LDS_PIN_LO) + 11];
    else if (t >= `LDS_CELL_LO && t != `LDS_RESERVED)
      trig_level = logic_cell_sync(2'(t - `LDS_CELL_LO));
  end

  assign trig_event = trig_level & ~trig_prev_q;
  assign at_top     = pwm_counter == period_buf_q;

  //////////////////////////////////////////////////////////////////////////////
  // load request: software bit or trigger edge, cleared at a period end or by a control write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_request_q <= 1'b0;
      trig_prev_q    <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_level;
      // R12: a fresh request beats the hardware clear in the same cycle
      if ((wr_en && idx == `IDX_CONTROL && pwdata[`CTL_LD_BIT]) || (enable_q && trig_event))
        load_request_q <= 1'b1;
      else if ((wr_en && idx == `IDX_CONTROL) || (pwm_clk_en && at_top && ers_state_q != ERS_HELD))
        load_request_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt_q  <= 8'h00;
      pwm_clk_en <= 1'b0;
    end
    // R13: disabled module clears prescale count
    else if (!enable_q)
    begin
      pre_cnt_q  <= 8'h00;
      pwm_clk_en <= 1'b0;
    end
    else
    begin
      pwm_clk_en <= 1'b0;
      if (tick)
      begin
        // R8: divide by prescale plus one
        if (pre_cnt_q == prescale_reg_q)
        begin
          pre_cnt_q  <= 8'h00;
          pwm_clk_en <= 1'b1;
        end
        else
          pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external reset sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ers_state_q <= ERS_IDLE;
    else if (!enable_q)
      ers_state_q <= ERS_IDLE;
    else if (pwm_clk_en)
    begin
      case (ers_state_q)
        ERS_IDLE:  if (ers_level) ers_state_q <= ers_now_q || at_top ? ERS_HELD : ERS_ARMED;
        ERS_ARMED: if (!ers_level) ers_state_q <= ERS_IDLE; else if (at_top) ers_state_q <= ERS_HELD;
        // R11: held until the reset level falls
        ERS_HELD:  if (!ers_level) ers_state_q <= ERS_IDLE;
        default:   ers_state_q <= ERS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // period counter and buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_counter   <= 16'h0000;
      period_buf_q  <= `PERIOD_RST;
      period_event  <= 1'b0;
      enable_prev_q <= 1'b0;
    end
    else
    begin
      enable_prev_q <= enable_q;
      period_event  <= 1'b0;
      // buffer takes the register when the module is enabled
      if (enable_q && !enable_prev_q)
        period_buf_q <= period_reg_q;
      if (!enable_q)
        pwm_counter <= 16'h0000;
      else if (pwm_clk_en)
      begin
        // R11: reset source clears and holds the counter
        if (ers_state_q == ERS_HELD || (ers_level && (ers_now_q || at_top)))
          pwm_counter <= 16'h0000;
        // R10: wrap after reaching the period value
        else if (at_top)
        begin
          pwm_counter  <= 16'h0000;
          period_event <= 1'b1;
          // R12: pending request loads at period end
          if (load_request_q)
            period_buf_q <= period_reg_q;
        end
        else
          pwm_counter <= pwm_counter + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // period interrupt postscaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      post_cnt_q <= 8'h00;
      period_irq <= 1'b0;
    end
    else
    begin
      period_irq <= 1'b0;
      // R11: external reset also clears the postscaler
      if (!enable_q || ers_state_q == ERS_HELD)
        post_cnt_q <= 8'h00;
      else if (period_event)
      begin
        // R9: one interrupt per postscale plus one events
        if (post_cnt_q == postscale_reg_q)
        begin
          post_cnt_q <= 8'h00;
          period_irq <= 1'b1;
        end
        else
          post_cnt_q <= post_cnt_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_top_reached;
    enable_q && pwm_clk_en && at_top && ers_state_q == ERS_IDLE && !ers_level;
  endsequence

  a_period_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R10
    s_top_reached |=> period_event && pwm_counter == 16'h0000)
    else $error("counter did not wrap at period value");
  a_held_at_zero: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (ers_state_q == ERS_HELD) |=> pwm_counter == 16'h0000 && !period_event)
    else $error("counter moved while held by external reset");
  a_ers_disabled_codes: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (ext_reset_source_reg_q[3:0] inside {4'h0, 4'he, 4'hf}) |-> !ers_level)
    else $error("disabled reset code produced a reset level");
  a_prescale_clear: assert property (@(posedge pclk) disable iff (!presetn) // R13
    !enable_q |=> pre_cnt_q == 8'h00 && !pwm_clk_en)
    else $error("prescale count not cleared while disabled");
  a_prescale_step: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (enable_q && tick && pre_cnt_q != prescale_reg_q) |=> !pwm_clk_en)
    else $error("pwm clock enable before prescale reached");
  a_load_transfer: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (s_top_reached and load_request_q && !trig_event && !wr_en)
      |=> period_buf_q == $past(period_reg_q) && !load_request_q)
    else $error("pending load not transferred at period end");
  a_post_irq: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (period_event && enable_q && ers_state_q != ERS_HELD && post_cnt_q != postscale_reg_q)
      |=> !period_irq)
    else $error("period interrupt before postscale count");
  a_post_fire: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (period_event && enable_q && ers_state_q != ERS_HELD && post_cnt_q == postscale_reg_q)
      |=> period_irq)
    else $error("period interrupt missing at postscale count");
  a_trigger_off: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (load_trigger_reg_q[2:0] inside {3'h0, 3'h7}) |-> !trig_level)
    else $error("disabled trigger code produced a level");
endmodule
`default_nettype wire

// ---- tb/source_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// stands in for the oscillators feeding the clock selector
// free running, each level lasts well over two pclk periods
module source_model
(
  output logic osc_wave
);
  initial osc_wave = 1'b0;
  // unrelated to pclk on purpose, so edges land anywhere in a cycle
  always #60 osc_wave = ~osc_wave;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_defs.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep, ers_pin, en_w, pev, pirq, osc;
  logic [15:0] paddr, cnt;
  logic [31:0] pwdata, prdata;
  logic [5:0]  trig;       // {cells 4..1, pin1, pin0}
  logic [7:0]  slice;      // other slice outputs
  logic [32:0] rd_q[$];    // {pslverr, prdata} notes
  int          gap_q[$];   // cycles between period events
  int          irq_q[$];   // events per interrupt
  int          n_mismatch, n_tests, gap, ev_n, ev_tot, e0, i, p, q;
  int          ers_c[7] = '{0, 2, 3, 14, 15, 1, 9};
  source_model src (.osc_wave(osc));
  pwm_timebase uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .pwm_pin_input0(trig[0]), .pwm_pin_input1(trig[1]), .fast_internal_osc(osc), .slow_internal_osc(osc),
    .medium_internal_osc_fast(osc), .medium_internal_osc_slow(osc), .secondary_osc(osc), .external_osc(osc),
    .reference_clock_out(osc), .numeric_osc_out(osc), .logic_cell_out(trig[5:2]),
    .ext_reset_pin_input(ers_pin), .other_slice_out(slice), .pwm_counter(cnt), .period_event(pev),
    .period_irq(pirq));
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  // a used-up wait counts against the run and ends it
  task automatic bound(input int t);
    if (t >= 2000)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  // one apb transfer; starts at an edge so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [15:0] idx, input logic [32:0] e);
    int t;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx[13:0], 2'b00};
    pwdata <= e[31:0];
    if (!w)
      rd_q.push_back(e);
    if (w && idx == `IDX_CONTROL)
      en_w <= e[7];
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 2000 && pready !== 1'b1; t++)
      @(posedge pclk);
    bound(t);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {25'h0, d});
  endtask
  task automatic cfg(input logic [7:0] ck, input logic [7:0] pr, input logic [7:0] pre);
    wr(`IDX_CONTROL, 8'h00);
    wr(`IDX_EXT_RESET_SRC, 8'h00);
    wr(`IDX_PERIOD_HIGH, 8'h00);
    wr(`IDX_PERIOD_LOW, pr);
    wr(`IDX_PRESCALE, pre);
    wr(`IDX_POSTSCALE, 8'h02);
    wr(`IDX_CLOCK_SEL, ck);
  endtask
  // mark the event count, then let n cycles pass
  task automatic idle(input int n);
    @(negedge pclk);
    e0 = ev_tot;
    repeat (n) @(negedge pclk);
  endtask
  // wait for one event (d=0) or for all notes to be used (d=1)
  task automatic await(input bit d);
    int t;
    @(negedge pclk);
    e0 = ev_tot;
    for (t = 0; t < 2000 && (d ? gap_q.size() + irq_q.size() > 0 : ev_tot == e0); t++)
      @(negedge pclk);
    bound(t);
  endtask
  ////////////////////////////////////////////////////////////////
  // watcher: takes the oldest note whenever a result shows
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      chk("read", rd_q.pop_front(), {pslverr, prdata});
    if (!en_w)
      ev_n = 0;
    // interrupt first: it belongs to events already counted
    if (pirq === 1'b1)
    begin
      if (irq_q.size() > 0)
        chk("irq", irq_q.pop_front(), ev_n);
      ev_n = 0;
    end
    if (pev === 1'b1)
    begin
      ev_tot++;
      ev_n++;
      if (gap_q.size() > 0)
        chk("gap", gap_q.pop_front(), gap);
      gap = 0;
    end
    gap++;
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, sleep, ers_pin, en_w} = '0;
    {paddr, pwdata, trig, slice} = '0;
    p = $urandom(35);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IDX_PERIOD_HIGH, 33'h0);
    apb(1'b0, `IDX_PRESCALE, 33'h0);
    apb(1'b0, 16'h0400, 33'h1_0000_0000);
    p = $urandom;
    wr(`IDX_PERIOD_LOW, p[7:0]);
    wr(`IDX_PERIOD_HIGH, p[15:8]);
    apb(1'b0, `IDX_PERIOD_LOW, {25'h0, p[7:0]});
    apb(1'b0, `IDX_PERIOD_HIGH, {25'h0, p[15:8]});
    $display("test registers done");
    // random period and prescale, postscale 2 gives an interrupt every third event
    for (i = 0; i < 4; i++)
    begin
      p = $urandom % 8;
      q = $urandom % 4;
      cfg(8'h02, p[7:0], q[7:0]);
      irq_q = '{3, 3};
      wr(`IDX_CONTROL, 8'h80);
      await(1'b0);
      gap_q = '{(p + 1) * (q + 1), (p + 1) * (q + 1), (p + 1) * (q + 1)};
      await(1'b1);
    end
    $display("test period done");
    cfg(8'h0f, 8'h03, 8'h00);
    wr(`IDX_CONTROL, 8'h80);
    idle(60);
    chk("reserved_clock", 0, ev_tot - e0);
    @(posedge pclk);
    sleep <= 1'b1;
    cfg(8'h02, 8'h03, 8'h00);
    wr(`IDX_CONTROL, 8'h80);
    idle(60);
    chk("sleep_sysclk", 0, ev_tot - e0);
    cfg(8'h03, 8'h03, 8'h00);
    wr(`IDX_CONTROL, 8'h80);
    idle(100);
    chk("sleep_osc", 1, ev_tot != e0);
    @(posedge pclk);
    sleep <= 1'b0;
    $display("test clock done");
    // reset level active on the pin and every slice; own and reserved codes must not hold
    ers_pin <= 1'b1;
    slice   <= 8'hff;
    foreach (ers_c[i])
    begin
      cfg(8'h02, 8'h03, 8'h00);
      wr(`IDX_EXT_RESET_SRC, ers_c[i][7:0]);
      wr(`IDX_CONTROL, 8'h81);
      idle(40);
      chk("ext_reset", ers_c[i] != 1 && ers_c[i] != 9, ev_tot != e0);
    end
    chk("held_count", 0, cnt);
    apb(1'b0, `IDX_STATUS, 33'h0_0001_0000);
    ers_pin <= 1'b0;
    slice   <= 8'h00;
    idle(40);
    chk("released", 1, ev_tot != e0);
    // active-low pin reset, armed until the first wrap, then held
    cfg(8'h02, 8'h03, 8'h00);
    wr(`IDX_EXT_RESET_SRC, 8'h01);
    wr(`IDX_CONTROL, 8'h82);
    idle(40);
    chk("ers_active_low", 0, ev_tot != e0);
    $display("test ext reset done");
    // period 5 running, new value 2 waits for a load trigger edge
    for (i = 0; i < 7; i++)
    begin
      cfg(8'h02, 8'h05, 8'h00);
      wr(`IDX_LOAD_TRIG, i[7:0]);
      wr(`IDX_CONTROL, 8'h80);
      wr(`IDX_PERIOD_LOW, 8'h02);
      trig[i == 0 ? 0 : i - 1] <= 1'b1;
      repeat (4) @(posedge pclk);
      trig <= '0;
      idle(40);
      await(1'b0);
      gap_q = '{i == 0 ? 6 : 3, i == 0 ? 6 : 3};
      await(1'b1);
    end
    $display("test load trigger done");
    summarize();
  end
endmodule
`default_nettype wire
